// ### src/emr_pkg.sv
package emr_pkg;
	localparam int ADDR_W = 8;
	localparam int DATA_W = 32;
	// Byte addresses = index * 4 (printed offsets are register indices)
	localparam logic [7:0] IDX_TAP54 = 8'h20;
	localparam logic [7:0] IDX_TAP32 = 8'h21;
	localparam logic [7:0] IDX_MON_OVR = 8'h22;
	localparam logic [7:0] IDX_OVR_THR = 8'h23;
	localparam logic [7:0] IDX_CMD = 8'h24;
	localparam logic [7:0] IDX_CNT_HI = 8'h25;
	localparam logic [7:0] IDX_CNT_LO = 8'h26;
	localparam logic [7:0] IDX_HEO = 8'h27;
	localparam logic [7:0] IDX_VEO = 8'h28;
	localparam logic [7:0] IDX_VRANGE = 8'h29;
	localparam logic [7:0] IDX_TIMER = 8'h2A;
	localparam logic [7:0] IDX_MINHIT = 8'h2B;
	localparam logic [7:0] IDX_MERIT = 8'h2C;
	localparam logic [7:0] IDX_CHAN_CTRL = 8'h1E;
	localparam logic [7:0] IDX_IRQ_STAT = 8'h30;
	localparam logic [7:0] IDX_IRQ_CLR = 8'h31;
	localparam logic [7:0] IDX_IRQ_EN = 8'h32;
	localparam logic [7:0] RST_TAP54 = 8'h00;
	localparam logic [7:0] RST_TAP32 = 8'h00;
	localparam logic [7:0] RST_MON_OVR = 8'h00;
	localparam logic [7:0] RST_OVR_THR = 8'h40;
	localparam logic [7:0] RST_TIMER = 8'h30;
	localparam logic [7:0] RST_MINHIT = 8'h00;
	localparam logic [7:0] RST_MERIT = 8'h72;
	localparam logic [7:0] RST_CHAN_CTRL = 8'hE1;
	localparam int B_FAST = 7;
	localparam int B_ERR_LOCK = 6;
	localparam int B_ERR_HITS = 5;
	localparam int B_ERR_VIS = 4;
	localparam int B_RSVD3 = 3;
	localparam int B_ADAPT = 2;
	localparam int B_MEAS = 1;
	localparam int B_COUNT = 0;
	localparam int B_MEAS_OVR = 7;
	localparam int B_EQ_OVR = 6;
	localparam int B_SCALE = 6;
	localparam int B_DFE_OFF = 3;
	localparam logic [1:0] RESP_OKAY = 2'b00;
	localparam logic [1:0] RESP_SLVERR = 2'b10;
	// Irq status bits: 0 adapt done, 1 measure done, 2 count done
	localparam int IRQ_N = 3;
	localparam logic [1:0] MERIT_INVALID = 2'b00;
	typedef struct packed {
		logic [3:0] tap5;
		logic [3:0] tap4;
		logic [3:0] tap3;
		logic [3:0] tap2;
		logic manual;
		logic dfe_off;
	} emr_eq_t;
	typedef struct packed {
		logic adapt_done;
		logic adapt_no_lock;
		logic meas_done;
		logic meas_no_hits;
		logic meas_no_vert;
		logic [7:0] horizontal_eye_opening;
		logic [7:0] vertical_eye_opening;
		logic count_done;
		logic [15:0] count;
	} emr_res_t;
endpackage : emr_pkg

// ### src/emr_regs.sv
// Design decision made here: the AXI4-Lite slave port.
`timescale 1ns/100ps
// How it works
// - 0x20 holds tap5 high, tap4 low nibble
// - 0x21 holds tap3 high, tap2 low nibble
// - 0x23 measure override, equalizer override, threshold
// - 0x24 bit7 enables fast monitor mode
// - 0x24 bits 6,5 no-lock, no-hits error flags
// - 0x24 bit4 vertical eye not visible flag
// - 0x24 bit2 starts adaptation, self clears
// - 0x24 bit1 starts eye measurement, self clears
// - 0x24 bit0 starts monitor counter, self clears
// - 0x25/0x26 read sixteen-bit monitor count
// - 0x27 horizontal, 0x28 vertical opening read-only
// - 0x29 bits 6:5 read back voltage range
// - 0x2A timer threshold, resets to 0x30
// - 0x2B bits 3:0 minimum hit count
// - 0x2C bit6 scales vertical opening by range
// - 0x2C bits 5:4 pick figure of merit
// - 0x2C bits 3:0 look-beyond search count
// - 0x1E bit3 switches equalizer off
module emr_regs (
	input wire logic ref_clk,
	input wire logic rst_b,
	input wire logic [emr_pkg::ADDR_W-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [emr_pkg::DATA_W-1:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [emr_pkg::ADDR_W-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [emr_pkg::DATA_W-1:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire emr_pkg::emr_res_t res_in,
	input wire logic [1:0] vrange_in,
	output emr_pkg::emr_eq_t eq_out,
	output logic [5:0] eye_thr_level,
	output logic meas_override,
	output logic mon_override,
	output logic fast_mode,
	output logic adapt_start,
	output logic meas_start,
	output logic count_start,
	output logic [7:0] timer_thr,
	output logic [3:0] min_hits,
	output logic scale_veo,
	output logic [1:0] merit_type,
	output logic [3:0] look_beyond,
	output logic irq
);
	typedef enum {W_IDLE, W_RESP} emr_wst_t;
	emr_wst_t wst_ff;
	logic aw_got_ff, w_got_ff;
	logic [5:0] aw_idx_ff;
	logic [7:0] wbyte_ff;
	logic wen_ff;
	logic [1:0] bresp_ff;
	logic bvalid_ff, rvalid_ff;
	logic [31:0] rdata_ff;
	logic [1:0] rresp_ff;
	logic [7:0] tap54_ff, tap32_ff, mon_ovr_ff, ovr_thr_ff, timer_ff, minhit_ff, merit_ff;
	logic [7:0] chan_ff;
	logic fast_ff, rsvd3_ff;
	logic adapt_ff, meas_ff, count_ff;
	logic err_lock_ff, err_hits_ff, err_vis_ff;
	logic [15:0] count_val_ff;
	logic [7:0] heo_ff, veo_ff;
	logic [5:0] vr_rsvd_ff;
	logic [emr_pkg::IRQ_N-1:0] irq_stat_ff, irq_en_ff;
	logic irq_ff;
	logic adapt_go_ff, meas_go_ff, count_go_ff;
	logic awrdy_ff, wrdy_ff, arrdy_ff;

	function automatic logic hit(input logic [5:0] idx, input logic [7:0] reg_idx);
		hit = ({2'b00, idx} == reg_idx);
	endfunction : hit

	// Word index from byte address
	wire logic [5:0] aw_idx = s_axi_awaddr[7:2];
	wire logic [5:0] ar_idx = s_axi_araddr[7:2];
	// Readies come from flops; each is low while its half of a write is held
	wire logic aw_take = s_axi_awvalid && awrdy_ff;
	wire logic w_take = s_axi_wvalid && wrdy_ff;
	wire logic wr_done = wst_ff == W_RESP && bvalid_ff && s_axi_bready;
	wire logic nxt_aw_got = (aw_got_ff || aw_take) && !wr_done;
	wire logic nxt_w_got = (w_got_ff || w_take) && !wr_done;
	wire logic wr_go = wen_ff;
	wire logic [7:0] wb = wbyte_ff;
	wire logic wr_mapped = hit(aw_idx_ff, emr_pkg::IDX_TAP54) || hit(aw_idx_ff, emr_pkg::IDX_TAP32)
		|| hit(aw_idx_ff, emr_pkg::IDX_MON_OVR) || hit(aw_idx_ff, emr_pkg::IDX_OVR_THR)
		|| hit(aw_idx_ff, emr_pkg::IDX_CMD) || hit(aw_idx_ff, emr_pkg::IDX_CNT_HI)
		|| hit(aw_idx_ff, emr_pkg::IDX_CNT_LO) || hit(aw_idx_ff, emr_pkg::IDX_HEO)
		|| hit(aw_idx_ff, emr_pkg::IDX_VEO) || hit(aw_idx_ff, emr_pkg::IDX_VRANGE)
		|| hit(aw_idx_ff, emr_pkg::IDX_TIMER) || hit(aw_idx_ff, emr_pkg::IDX_MINHIT)
		|| hit(aw_idx_ff, emr_pkg::IDX_MERIT) || hit(aw_idx_ff, emr_pkg::IDX_CHAN_CTRL)
		|| hit(aw_idx_ff, emr_pkg::IDX_IRQ_STAT) || hit(aw_idx_ff, emr_pkg::IDX_IRQ_CLR)
		|| hit(aw_idx_ff, emr_pkg::IDX_IRQ_EN);
	wire logic wr_cmd = wr_go && hit(aw_idx_ff, emr_pkg::IDX_CMD);
	// Start only when idle; a write of one while busy is absorbed
	wire logic nxt_adapt_go = wr_cmd && wb[emr_pkg::B_ADAPT] && !adapt_ff;
	wire logic nxt_meas_go = wr_cmd && wb[emr_pkg::B_MEAS] && !meas_ff;
	wire logic nxt_count_go = wr_cmd && wb[emr_pkg::B_COUNT] && !count_ff;
	wire logic [emr_pkg::IRQ_N-1:0] irq_evt = {res_in.count_done && count_ff,
		res_in.meas_done && meas_ff, res_in.adapt_done && adapt_ff};
	wire logic [emr_pkg::IRQ_N-1:0] irq_clr = (wr_go && hit(aw_idx_ff, emr_pkg::IDX_IRQ_CLR))
		? wb[emr_pkg::IRQ_N-1:0] : '0;
	wire logic [7:0] cmd_rd = {fast_ff, err_lock_ff, err_hits_ff, err_vis_ff, rsvd3_ff,
		adapt_ff, meas_ff, count_ff};
	wire logic [7:0] vr_rd = {vr_rsvd_ff[5], vrange_in, vr_rsvd_ff[4:0]};
	wire logic [7:0] rd_byte =
		hit(ar_idx, emr_pkg::IDX_TAP54) ? tap54_ff :
		hit(ar_idx, emr_pkg::IDX_TAP32) ? tap32_ff :
		hit(ar_idx, emr_pkg::IDX_MON_OVR) ? mon_ovr_ff :
		hit(ar_idx, emr_pkg::IDX_OVR_THR) ? ovr_thr_ff :
		hit(ar_idx, emr_pkg::IDX_CMD) ? cmd_rd :
		hit(ar_idx, emr_pkg::IDX_CNT_HI) ? count_val_ff[15:8] :
		hit(ar_idx, emr_pkg::IDX_CNT_LO) ? count_val_ff[7:0] :
		hit(ar_idx, emr_pkg::IDX_HEO) ? heo_ff :
		hit(ar_idx, emr_pkg::IDX_VEO) ? veo_ff :
		hit(ar_idx, emr_pkg::IDX_VRANGE) ? vr_rd :
		hit(ar_idx, emr_pkg::IDX_TIMER) ? timer_ff :
		hit(ar_idx, emr_pkg::IDX_MINHIT) ? minhit_ff :
		hit(ar_idx, emr_pkg::IDX_MERIT) ? merit_ff :
		hit(ar_idx, emr_pkg::IDX_CHAN_CTRL) ? chan_ff :
		hit(ar_idx, emr_pkg::IDX_IRQ_STAT) ? {5'h00, irq_stat_ff} :
		hit(ar_idx, emr_pkg::IDX_IRQ_EN) ? {5'h00, irq_en_ff} : 8'h00;
	wire logic rd_mapped = (rd_byte != 8'h00) || hit(ar_idx, emr_pkg::IDX_TAP54)
		|| (ar_idx >= emr_pkg::IDX_TAP32[5:0] && ar_idx <= emr_pkg::IDX_MERIT[5:0])
		|| hit(ar_idx, emr_pkg::IDX_CHAN_CTRL) || hit(ar_idx, emr_pkg::IDX_IRQ_STAT)
		|| hit(ar_idx, emr_pkg::IDX_IRQ_EN);
	wire logic rd_take = s_axi_arvalid && arrdy_ff;
	wire logic nxt_rvalid = rd_take || (rvalid_ff && !s_axi_rready);
	// Irq uses next status and next enable so it never lags an enable write
	wire logic [emr_pkg::IRQ_N-1:0] nxt_irq_stat = (irq_stat_ff & ~irq_clr) | irq_evt;
	wire logic [emr_pkg::IRQ_N-1:0] nxt_irq_en = (wr_go && hit(aw_idx_ff, emr_pkg::IDX_IRQ_EN))
		? wb[emr_pkg::IRQ_N-1:0] : irq_en_ff;

	// Write channel: address and data taken in either order
	always_ff @(posedge ref_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			wst_ff <= W_IDLE;
			aw_got_ff <= 1'b0;
			w_got_ff <= 1'b0;
			aw_idx_ff <= 6'h00;
			wbyte_ff <= 8'h00;
			wen_ff <= 1'b0;
			bvalid_ff <= 1'b0;
			bresp_ff <= emr_pkg::RESP_OKAY;
			awrdy_ff <= 1'b0;
			wrdy_ff <= 1'b0;
		end
		else
		begin
			wen_ff <= 1'b0;
			awrdy_ff <= !nxt_aw_got;
			wrdy_ff <= !nxt_w_got;
			if (aw_take)
			begin
				aw_got_ff <= 1'b1;
				aw_idx_ff <= aw_idx;
			end
			if (w_take)
			begin
				w_got_ff <= 1'b1;
				wbyte_ff <= s_axi_wstrb[0] ? s_axi_wdata[7:0] : 8'h00;
			end
			unique case (wst_ff)
				W_IDLE:
					if ((aw_got_ff || aw_take) && (w_got_ff || w_take)
						&& !(aw_take || w_take))
					begin
						wen_ff <= 1'b1;
						wst_ff <= W_RESP;
					end
				W_RESP:
					if (!wen_ff && !bvalid_ff)
					begin
						bvalid_ff <= 1'b1;
						bresp_ff <= wr_mapped ? emr_pkg::RESP_OKAY : emr_pkg::RESP_SLVERR;
					end
					else if (bvalid_ff && s_axi_bready)
					begin
						bvalid_ff <= 1'b0;
						aw_got_ff <= 1'b0;
						w_got_ff <= 1'b0;
						wst_ff <= W_IDLE;
					end
			endcase
		end
	end

	// Read channel: one-cycle lookup
	always_ff @(posedge ref_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			arrdy_ff <= 1'b0;
			rvalid_ff <= 1'b0;
			rdata_ff <= 32'h0000_0000;
			rresp_ff <= emr_pkg::RESP_OKAY;
		end
		else
		begin
			arrdy_ff <= !nxt_rvalid;
			rvalid_ff <= nxt_rvalid;
			if (rd_take)
			begin
				rdata_ff <= {24'h00_0000, rd_byte};
				rresp_ff <= rd_mapped ? emr_pkg::RESP_OKAY : emr_pkg::RESP_SLVERR;
			end
		end
	end

	// Plain read/write fields; wstrb lane 0 only
	always_ff @(posedge ref_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			tap54_ff <= emr_pkg::RST_TAP54;
			tap32_ff <= emr_pkg::RST_TAP32;
			mon_ovr_ff <= emr_pkg::RST_MON_OVR;
			ovr_thr_ff <= emr_pkg::RST_OVR_THR;
			timer_ff <= emr_pkg::RST_TIMER;
			minhit_ff <= emr_pkg::RST_MINHIT;
			merit_ff <= emr_pkg::RST_MERIT;
			chan_ff <= emr_pkg::RST_CHAN_CTRL;
			fast_ff <= 1'b0;
			rsvd3_ff <= 1'b0;
			vr_rsvd_ff <= 6'h00;
			irq_en_ff <= '0;
		end
		else if (wr_go)
		begin
			if (hit(aw_idx_ff, emr_pkg::IDX_TAP54)) tap54_ff <= wb;
			if (hit(aw_idx_ff, emr_pkg::IDX_TAP32)) tap32_ff <= wb;
			if (hit(aw_idx_ff, emr_pkg::IDX_MON_OVR)) mon_ovr_ff <= wb;
			if (hit(aw_idx_ff, emr_pkg::IDX_OVR_THR)) ovr_thr_ff <= wb;
			if (hit(aw_idx_ff, emr_pkg::IDX_TIMER)) timer_ff <= wb;
			if (hit(aw_idx_ff, emr_pkg::IDX_MINHIT)) minhit_ff <= wb;
			if (hit(aw_idx_ff, emr_pkg::IDX_MERIT)) merit_ff <= wb;
			if (hit(aw_idx_ff, emr_pkg::IDX_CHAN_CTRL)) chan_ff <= wb;
			if (hit(aw_idx_ff, emr_pkg::IDX_IRQ_EN)) irq_en_ff <= wb[emr_pkg::IRQ_N-1:0];
			if (hit(aw_idx_ff, emr_pkg::IDX_VRANGE)) vr_rsvd_ff <= {wb[7], wb[4:0]};
			if (wr_cmd)
			begin
				fast_ff <= wb[emr_pkg::B_FAST];
				rsvd3_ff <= wb[emr_pkg::B_RSVD3];
			end
		end
	end

	// Start bits stay high until the engine reports done; results land with done
	always_ff @(posedge ref_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			adapt_ff <= 1'b0;
			meas_ff <= 1'b0;
			count_ff <= 1'b0;
			adapt_go_ff <= 1'b0;
			meas_go_ff <= 1'b0;
			count_go_ff <= 1'b0;
			err_lock_ff <= 1'b0;
			err_hits_ff <= 1'b0;
			err_vis_ff <= 1'b0;
			count_val_ff <= 16'h0000;
			heo_ff <= 8'h00;
			veo_ff <= 8'h00;
		end
		else
		begin
			adapt_go_ff <= nxt_adapt_go;
			meas_go_ff <= nxt_meas_go;
			count_go_ff <= nxt_count_go;
			if (nxt_adapt_go)
				adapt_ff <= 1'b1;
			else if (adapt_ff && res_in.adapt_done)
			begin
				adapt_ff <= 1'b0;
				err_lock_ff <= res_in.adapt_no_lock;
			end
			if (nxt_meas_go)
				meas_ff <= 1'b1;
			else if (meas_ff && res_in.meas_done)
			begin
				meas_ff <= 1'b0;
				err_hits_ff <= res_in.meas_no_hits;
				err_vis_ff <= res_in.meas_no_vert;
				heo_ff <= res_in.horizontal_eye_opening;
				veo_ff <= res_in.vertical_eye_opening;
			end
			if (nxt_count_go)
				count_ff <= 1'b1;
			else if (count_ff && res_in.count_done)
			begin
				count_ff <= 1'b0;
				count_val_ff <= res_in.count;
			end
		end
	end

	// Sticky done flags; set wins over clear
	always_ff @(posedge ref_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			irq_stat_ff <= '0;
			irq_ff <= 1'b0;
		end
		else
		begin
			irq_stat_ff <= nxt_irq_stat;
			irq_ff <= |(nxt_irq_stat & nxt_irq_en);
		end
	end

	assign s_axi_awready = awrdy_ff;
	assign s_axi_wready = wrdy_ff;
	assign s_axi_bvalid = bvalid_ff;
	assign s_axi_bresp = bresp_ff;
	assign s_axi_arready = arrdy_ff;
	assign s_axi_rvalid = rvalid_ff;
	assign s_axi_rdata = rdata_ff;
	assign s_axi_rresp = rresp_ff;
	// Tap weights always drive eq_out; the manual override bit from 0x23 bit6 travels with them
	assign eq_out = {tap54_ff, tap32_ff, ovr_thr_ff[emr_pkg::B_EQ_OVR],
		chan_ff[emr_pkg::B_DFE_OFF]};
	assign eye_thr_level = ovr_thr_ff[5:0];
	assign meas_override = ovr_thr_ff[emr_pkg::B_MEAS_OVR];
	assign mon_override = mon_ovr_ff[7];
	assign fast_mode = fast_ff;
	assign adapt_start = adapt_go_ff;
	assign meas_start = meas_go_ff;
	assign count_start = count_go_ff;
	assign timer_thr = timer_ff;
	assign min_hits = minhit_ff[3:0];
	assign scale_veo = merit_ff[emr_pkg::B_SCALE];
	assign merit_type = merit_ff[5:4];
	assign look_beyond = merit_ff[3:0];
	assign irq = irq_ff;

	a_adapt_self_clear: assert property (@(posedge ref_clk) disable iff (!rst_b)
		adapt_ff && res_in.adapt_done && !nxt_adapt_go |=> !adapt_ff)
		else $error("adapt start bit did not clear");
	a_adapt_launch: assert property (@(posedge ref_clk) disable iff (!rst_b)
		nxt_adapt_go |=> adapt_ff && adapt_start)
		else $error("adapt start not launched");
	a_meas_launch: assert property (@(posedge ref_clk) disable iff (!rst_b)
		nxt_meas_go |=> meas_ff && meas_start ##1 !meas_start)
		else $error("measure start pulse wrong");
	a_count_launch: assert property (@(posedge ref_clk) disable iff (!rst_b)
		nxt_count_go |=> count_ff && count_start)
		else $error("count start not launched");
	a_count_capture: assert property (@(posedge ref_clk) disable iff (!rst_b)
		count_ff && res_in.count_done && !nxt_count_go |=> count_val_ff == $past(res_in.count))
		else $error("count not captured");
	a_heo_capture: assert property (@(posedge ref_clk) disable iff (!rst_b)
		meas_ff && res_in.meas_done && !nxt_meas_go |=> heo_ff == $past(res_in.horizontal_eye_opening)
		&& err_vis_ff == $past(res_in.meas_no_vert))
		else $error("measure results not captured");
	a_lock_flag: assert property (@(posedge ref_clk) disable iff (!rst_b)
		adapt_ff && res_in.adapt_done && !nxt_adapt_go |=> err_lock_ff == $past(res_in.adapt_no_lock))
		else $error("no-lock flag not captured");
	a_tap_write: assert property (@(posedge ref_clk) disable iff (!rst_b)
		wr_go && hit(aw_idx_ff, emr_pkg::IDX_TAP54) |=> eq_out.tap5 == $past(wb[7:4]))
		else $error("tap5 weight not written");
	a_irq_level: assert property (@(posedge ref_clk) disable iff (!rst_b)
		irq_ff == |(irq_stat_ff & irq_en_ff))
		else $error("irq out of step with status");
	c_adapt_run: cover property (@(posedge ref_clk) disable iff (!rst_b)
		adapt_start ##[1:100] (adapt_ff && res_in.adapt_done));
	c_meas_run: cover property (@(posedge ref_clk) disable iff (!rst_b)
		meas_start ##[1:100] (meas_ff && res_in.meas_done));
	c_irq_seen: cover property (@(posedge ref_clk) disable iff (!rst_b) $rose(irq));
endmodule : emr_regs

// ### verif/tb_top.sv
`timescale 1ns/100ps
module tb_top;
	logic ref_clk = 1'b0;
	logic rst_b;
	logic [7:0] awa = 8'h00;
	logic [7:0] ara = 8'h00;
	logic awv = 1'b0;
	logic wv = 1'b0;
	logic bre = 1'b0;
	logic arv = 1'b0;
	logic rre = 1'b0;
	logic [31:0] wd = 32'h00000000;
	logic [3:0] ws = 4'h0;
	logic awr, wrd, bv, arr, rv;
	logic [1:0] br, rr;
	logic [31:0] rd;
	emr_pkg::emr_res_t res = '0;
	emr_pkg::emr_res_t r;
	logic [1:0] vr = 2'b00;
	emr_pkg::emr_eq_t eq;
	logic [5:0] thr;
	logic mo, mno, fm, ast, mst, cst, sv, irq;
	logic [7:0] tt;
	logic [3:0] mh, lb;
	logic [1:0] mt;
	int failures = 0;
	int n_tests = 0;
	int cyc = 0;
	int n_ad = 0;
	int n_ms = 0;
	int n_ct = 0;
	logic [7:0] rst_tab [13] = '{8'h00, 8'h00, 8'h00, 8'h40, 8'h00, 8'h00, 8'h00, 8'h00,
		8'h00, 8'h00, 8'h30, 8'h00, 8'h72};
	localparam logic [1:0] OK = emr_pkg::RESP_OKAY;
	localparam logic [1:0] ERR = emr_pkg::RESP_SLVERR;

	emr_regs dut (.ref_clk(ref_clk), .rst_b(rst_b), .s_axi_awaddr(awa), .s_axi_awvalid(awv),
		.s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(ws), .s_axi_wvalid(wv),
		.s_axi_wready(wrd), .s_axi_bresp(br), .s_axi_bvalid(bv), .s_axi_bready(bre),
		.s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rd),
		.s_axi_rresp(rr), .s_axi_rvalid(rv), .s_axi_rready(rre), .res_in(res),
		.vrange_in(vr), .eq_out(eq), .eye_thr_level(thr), .meas_override(mo),
		.mon_override(mno), .fast_mode(fm), .adapt_start(ast), .meas_start(mst),
		.count_start(cst), .timer_thr(tt), .min_hits(mh), .scale_veo(sv),
		.merit_type(mt), .look_beyond(lb), .irq(irq));

	always #2.5 ref_clk = ~ref_clk;

	task automatic wrap_up();
		$display("failures=%0d n_tests=%0d", failures, n_tests);
		if (failures == 0 && n_tests > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : wrap_up

	task automatic chk(input logic [31:0] g, input logic [31:0] e, input string m);
		n_tests++;
		if (g !== e)
		begin
			failures++;
			$display("[FAIL] %0t %s got %0h exp %0h", $time, m, g, e);
		end
	endtask : chk

	// Write side: both channels offered together, each dropped once taken
	task automatic wr(input logic [7:0] idx, input logic [7:0] d, input logic [1:0] er);
		logic got;
		got = 1'b0;
		@(posedge ref_clk);
		awa <= {idx[5:0], 2'b00};
		wd <= {24'h000000, d};
		ws <= 4'hF;
		awv <= 1'b1;
		wv <= 1'b1;
		bre <= 1'b1;
		while (!got)
		begin
			@(posedge ref_clk);
			if (awv && awr)
				awv <= 1'b0;
			if (wv && wrd)
				wv <= 1'b0;
			if (bv === 1'b1)
			begin
				got = 1'b1;
				bre <= 1'b0;
				chk({30'h0, br}, {30'h0, er}, "write response");
			end
		end
	endtask : wr

	task automatic rdc(input logic [7:0] idx, input logic [7:0] mk, input logic [7:0] e,
		input logic [1:0] er);
		logic got;
		got = 1'b0;
		@(posedge ref_clk);
		ara <= {idx[5:0], 2'b00};
		arv <= 1'b1;
		rre <= 1'b1;
		while (!got)
		begin
			@(posedge ref_clk);
			if (arv && arr)
				arv <= 1'b0;
			if (rv === 1'b1)
			begin
				got = 1'b1;
				rre <= 1'b0;
				chk(rd & {24'h000000, mk}, {24'h000000, e & mk}, "read data");
				chk({30'h0, rr}, {30'h0, er}, "read response");
			end
		end
	endtask : rdc

	// Results stay put after done, as a real engine would leave them
	task automatic fire(input emr_pkg::emr_res_t x);
		@(posedge ref_clk);
		res <= x;
		x.adapt_done = 1'b0;
		x.meas_done = 1'b0;
		x.count_done = 1'b0;
		@(posedge ref_clk);
		res <= x;
	endtask : fire

	always @(posedge ref_clk)
	begin
		cyc++;
		if (ast === 1'b1)
			n_ad++;
		if (mst === 1'b1)
			n_ms++;
		if (cst === 1'b1)
			n_ct++;
		if (cyc == 8000)
		begin
			failures++;
			wrap_up();
		end
	end

	initial
	begin
		// Time-zero edge so the asynchronous reset really fires
		rst_b <= 1'b0;
		repeat (2) @(posedge ref_clk);
		rst_b <= 1'b1;
		chk({eq.manual, sv, mt, lb, tt}, {1'b1, 1'b1, 2'b11, 4'h2, 8'h30}, "reset out");
		chk({thr, mo, mno, fm, eq.dfe_off, irq}, 32'h0, "reset idle");
		for (int i = 0; i < 13; i++)
			rdc(8'h20 + i[7:0], 8'hFF, rst_tab[i], OK);
		wr(emr_pkg::IDX_TAP54, 8'h5A, OK);
		wr(emr_pkg::IDX_TAP32, 8'hC3, OK);
		wr(emr_pkg::IDX_OVR_THR, 8'hA5, OK);
		chk({eq.tap5, eq.tap4, eq.tap3, eq.tap2, eq.manual, mo, thr},
			{4'h5, 4'hA, 4'hC, 4'h3, 1'b0, 1'b1, 6'h25}, "weights");
		rdc(emr_pkg::IDX_TAP54, 8'hFF, 8'h5A, OK);
		rdc(emr_pkg::IDX_TAP32, 8'hFF, 8'hC3, OK);
		rdc(emr_pkg::IDX_OVR_THR, 8'hFF, 8'hA5, OK);
		wr(emr_pkg::IDX_IRQ_EN, 8'h07, OK);
		// Flag bits written as ones must not stick
		wr(emr_pkg::IDX_CMD, 8'hF4, OK);
		rdc(emr_pkg::IDX_CMD, 8'hF7, 8'h84, OK);
		chk({31'h0, fm}, 32'h1, "fast mode");
		wr(emr_pkg::IDX_CMD, 8'h84, OK);
		r = '0;
		r.adapt_done = 1'b1;
		r.adapt_no_lock = 1'b1;
		fire(r);
		rdc(emr_pkg::IDX_CMD, 8'h44, 8'h40, OK);
		chk(n_ad, 1, "adapt pulses");
		rdc(emr_pkg::IDX_IRQ_STAT, 8'h07, 8'h01, OK);
		chk({31'h0, irq}, 32'h1, "irq adapt");
		wr(emr_pkg::IDX_CMD, 8'h82, OK);
		rdc(emr_pkg::IDX_CMD, 8'h02, 8'h02, OK);
		r = '0;
		r.meas_done = 1'b1;
		r.meas_no_hits = 1'b1;
		r.meas_no_vert = 1'b1;
		r.horizontal_eye_opening = 8'h3F;
		r.vertical_eye_opening = 8'h21;
		fire(r);
		rdc(emr_pkg::IDX_CMD, 8'h32, 8'h30, OK);
		rdc(emr_pkg::IDX_HEO, 8'hFF, 8'h3F, OK);
		rdc(emr_pkg::IDX_VEO, 8'hFF, 8'h21, OK);
		chk(n_ms, 1, "measure pulses");
		wr(emr_pkg::IDX_IRQ_EN, 8'h03, OK);
		wr(emr_pkg::IDX_CMD, 8'h81, OK);
		r = '0;
		r.count_done = 1'b1;
		r.count = 16'hA55A;
		fire(r);
		rdc(emr_pkg::IDX_CNT_HI, 8'hFF, 8'hA5, OK);
		rdc(emr_pkg::IDX_CNT_LO, 8'hFF, 8'h5A, OK);
		rdc(emr_pkg::IDX_CMD, 8'h01, 8'h00, OK);
		chk(n_ct, 1, "count pulses");
		rdc(emr_pkg::IDX_IRQ_STAT, 8'h07, 8'h07, OK);
		wr(emr_pkg::IDX_IRQ_CLR, 8'h03, OK);
		rdc(emr_pkg::IDX_IRQ_STAT, 8'h07, 8'h04, OK);
		chk({31'h0, irq}, 32'h0, "irq masked");
		wr(emr_pkg::IDX_IRQ_EN, 8'h07, OK);
		repeat (2) @(posedge ref_clk);
		chk({31'h0, irq}, 32'h1, "irq unmasked");
		wr(emr_pkg::IDX_IRQ_CLR, 8'h04, OK);
		repeat (2) @(posedge ref_clk);
		chk({31'h0, irq}, 32'h0, "irq cleared");
		vr <= 2'b10;
		wr(emr_pkg::IDX_VRANGE, 8'h60, OK);
		rdc(emr_pkg::IDX_VRANGE, 8'hFF, 8'h40, OK);
		wr(emr_pkg::IDX_TIMER, 8'hA5, OK);
		rdc(emr_pkg::IDX_TIMER, 8'hFF, 8'hA5, OK);
		wr(emr_pkg::IDX_MINHIT, 8'h0F, OK);
		rdc(emr_pkg::IDX_MINHIT, 8'h0F, 8'h0F, OK);
		chk({tt, mh}, {8'hA5, 4'hF}, "timer hits");
		for (int m = 0; m < 4; m++)
		begin
			wr(emr_pkg::IDX_MERIT, {1'b0, m[0], m[1:0], 4'h9 + m[3:0]}, OK);
			chk({sv, mt, lb}, {m[0], m[1:0], 4'h9 + m[3:0]}, "merit");
			rdc(emr_pkg::IDX_MERIT, 8'h7F, {1'b0, m[0], m[1:0], 4'h9 + m[3:0]}, OK);
		end
		wr(emr_pkg::IDX_CHAN_CTRL, 8'hE9, OK);
		chk({31'h0, eq.dfe_off}, 32'h1, "equalizer off");
		wr(emr_pkg::IDX_CHAN_CTRL, 8'hE1, OK);
		chk({31'h0, eq.dfe_off}, 32'h0, "equalizer on");
		wr(emr_pkg::IDX_MON_OVR, 8'h80, OK);
		chk({31'h0, mno}, 32'h1, "monitor override");
		rdc(emr_pkg::IDX_MON_OVR, 8'hFF, 8'h80, OK);
		wr(8'h10, 8'hFF, ERR);
		rdc(8'h10, 8'hFF, 8'h00, ERR);
		wrap_up();
	end
endmodule : tb_top
